// >>> hw/pwmoc_params.svh
// Offsets, field positions, reset values and keys of the PWM output block
`ifndef PWMOC_PARAMS_SVH
`define PWMOC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PWMOC_OFS_PIN_IO 5'h00
`define PWMOC_OFS_TRIG 5'h04
`define PWMOC_OFS_FCL 5'h08
`define PWMOC_OFS_STATUS 5'h0c
`define PWMOC_OFS_UNLOCK 5'h10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PWMOC_RST_PIN_IO 16'hc000
`define PWMOC_RST_TRIG 16'h0000
`define PWMOC_RST_FCL 16'h00f8

// ----------------------------------------------------------------
// Source select codes and fields
// ----------------------------------------------------------------
`define PWMOC_SRC_CMP_FIRST 5'h08
`define PWMOC_SRC_CMP_LAST 5'h0c
`define PWMOC_SRC_FAULT32 5'h1f
`define PWMOC_FCL_USED_MASK 16'h7fff
`define PWMOC_STAT_CLR_BIT 0

// ----------------------------------------------------------------
// Unlock keys, written in this order
// ----------------------------------------------------------------
`define PWMOC_KEY_FIRST 16'h55aa
`define PWMOC_KEY_SECOND 16'haa55

`endif

// >>> hw/pwmoc_pkg.sv
// Types shared by the PWM output and limit control block
package pwmoc_pkg;

  typedef enum logic [1:0] {
    PWMOC_PAIR_COMPL = 2'b00,
    PWMOC_PAIR_REDUN = 2'b01,
    PWMOC_PAIR_PUSHP = 2'b10,
    PWMOC_PAIR_RSVD = 2'b11
  } pwmoc_pair_mode_t;

  typedef enum logic [1:0] {
    PWMOC_FLT_LATCHED = 2'b00,
    PWMOC_FLT_CYCLE = 2'b01,
    PWMOC_FLT_RSVD = 2'b10,
    PWMOC_FLT_OFF = 2'b11
  } pwmoc_fault_mode_t;

  typedef struct packed {
    logic high_pin_own;
    logic low_pin_own;
    logic high_pin_polarity;
    logic low_pin_polarity;
    pwmoc_pair_mode_t pin_pair_mode;
    logic high_override_en;
    logic low_override_en;
    logic [1:0] override_data;
    logic [1:0] fault_pin_data;
    logic [1:0] limit_pin_data;
    logic swap;
    logic override_sync;
  } pwmoc_pin_io_t;

  typedef struct packed {
    logic unused;
    logic [4:0] limit_source_sel;
    logic limit_polarity;
    logic limit_mode_en;
    logic [4:0] fault_source_sel;
    logic fault_polarity;
    pwmoc_fault_mode_t fault_mode;
  } pwmoc_fcl_t;

  typedef struct packed {
    logic high_override_en;
    logic low_override_en;
    logic [1:0] override_data;
  } pwmoc_ovr_t;

endpackage

// >>> hw/pwmoc_top.sv
// PWM output stage: pin ownership, modes, override, fault and limit forcing
`timescale 1ns/10ps
`default_nettype none
`include "pwmoc_params.svh"

module pwmoc_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Generator and time base
  input wire logic pwm_gen_in,
  input wire logic period_start_in,
  input wire logic time_base_tick_in,
  input wire logic [15:0] time_base_in,
  input wire logic local_time_base_in,
  input wire logic module_enable_in,
  input wire logic write_lock_config_in,
  // Fault and limit sources
  input wire logic [7:0] fault_inputs_in,
  input wire logic [4:0] comparator_in,
  input wire logic fault32_in,
  // Pins and trigger
  output logic high_output_pin_out,
  output logic low_output_pin_out,
  output logic high_output_pin_oe_out,
  output logic low_output_pin_oe_out,
  output logic adc_trigger_out
);
  import pwmoc_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  pwmoc_pin_io_t pin_io;
  pwmoc_fcl_t fcl;
  pwmoc_ovr_t ovr_live;
  logic [15:0] trig_cmp;
  logic ack;
  logic key_seen;
  logic unlocked;
  logic fault_latched;
  logic fault_cycle;
  logic push_phase;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = avs_read_in | avs_write_in;
  wire wr_go = avs_write_in & ack;
  wire lo_en = avs_byteenable_in[0];
  wire hi_en = avs_byteenable_in[1];
  wire [15:0] wdata = avs_writedata_in[15:0];
  wire sel_pin_io = avs_address_in == `PWMOC_OFS_PIN_IO;
  wire sel_trig = avs_address_in == `PWMOC_OFS_TRIG;
  wire sel_fcl = avs_address_in == `PWMOC_OFS_FCL;
  wire sel_stat = avs_address_in == `PWMOC_OFS_STATUS;
  wire sel_unlock = avs_address_in == `PWMOC_OFS_UNLOCK;
  // One wait state: request held one cycle, answered in the next
  assign avs_waitrequest_out = req & ~ack;

  wire may_write = ~write_lock_config_in | unlocked;
  wire wr_pin_io = wr_go & sel_pin_io & may_write;
  wire wr_fcl = wr_go & sel_fcl & may_write;
  // Compare value has no lock: it may move while running
  wire wr_trig = wr_go & sel_trig;
  wire wr_unlock = wr_go & sel_unlock;
  wire wr_stat_clr = wr_go & sel_stat & lo_en &
    wdata[`PWMOC_STAT_CLR_BIT];
  wire [15:0] lane_mask = {{8{hi_en}}, {8{lo_en}}};
  wire [15:0] next_pin_io = (pin_io & ~lane_mask) | (wdata & lane_mask);
  wire [15:0] next_fcl = ((fcl & ~lane_mask) | (wdata & lane_mask)) &
    `PWMOC_FCL_USED_MASK;
  wire [15:0] next_trig = (trig_cmp & ~lane_mask) | (wdata & lane_mask);

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  function automatic logic pick_source(input logic [4:0] code,
                                       input logic [7:0] faults,
                                       input logic [4:0] cmps,
                                       input logic f32);
    logic [4:0] cidx;
    cidx = code - `PWMOC_SRC_CMP_FIRST;
    if (code < `PWMOC_SRC_CMP_FIRST) begin
      pick_source = faults[code[2:0]];
    end else if (code <= `PWMOC_SRC_CMP_LAST) begin
      pick_source = cmps[cidx[2:0]];
    end else if (code == `PWMOC_SRC_FAULT32) begin
      pick_source = f32;
    end else begin
      // Reserved codes read as an idle source
      pick_source = 1'b0;
    end
  endfunction

  wire limit_raw = pick_source(fcl.limit_source_sel, fault_inputs_in,
    comparator_in, fault32_in);
  wire fault_raw = pick_source(fcl.fault_source_sel, fault_inputs_in,
    comparator_in, fault32_in);
  wire limit_src = limit_raw ^ fcl.limit_polarity;
  wire fault_src = fault_raw ^ fcl.fault_polarity;
  wire limit_active = fcl.limit_mode_en & limit_src;
  wire flt_latched_md = fcl.fault_mode == PWMOC_FLT_LATCHED;
  wire flt_cycle_md = fcl.fault_mode == PWMOC_FLT_CYCLE;
  wire fault_hit = fault_src & (flt_latched_md | flt_cycle_md);
  wire fault_active = fault_hit | (flt_latched_md & fault_latched) |
    (flt_cycle_md & fault_cycle);

  // ----------------------------------------------------------------
  // Pin signal path
  // ----------------------------------------------------------------
  // pair mode shaping
  logic gen_high;
  logic gen_low;
  always_comb begin
    gen_high = pwm_gen_in;
    gen_low = ~pwm_gen_in;
    unique case (pin_io.pin_pair_mode)
      PWMOC_PAIR_COMPL: begin
        gen_high = pwm_gen_in;
        gen_low = ~pwm_gen_in;
      end
      PWMOC_PAIR_REDUN: begin
        gen_high = pwm_gen_in;
        gen_low = pwm_gen_in;
      end
      PWMOC_PAIR_PUSHP: begin
        gen_high = pwm_gen_in & ~push_phase;
        gen_low = pwm_gen_in & push_phase;
      end
      // Reserved code: hold both pins inactive
      default: begin
        gen_high = 1'b0;
        gen_low = 1'b0;
      end
    endcase
  end

  wire sw_high = pin_io.swap ? gen_low : gen_high;
  wire sw_low = pin_io.swap ? gen_high : gen_low;
  wire lim_high = limit_active ? pin_io.limit_pin_data[1] : sw_high;
  wire lim_low = limit_active ? pin_io.limit_pin_data[0] : sw_low;
  wire flt_high = fault_active ? pin_io.fault_pin_data[1] : lim_high;
  wire flt_low = fault_active ? pin_io.fault_pin_data[0] : lim_low;
  wire ovr_high = ovr_live.high_override_en ?
    ovr_live.override_data[1] : flt_high;
  wire ovr_low = ovr_live.low_override_en ?
    ovr_live.override_data[0] : flt_low;
  wire next_high_pin = ovr_high ^ pin_io.high_pin_polarity;
  wire next_low_pin = ovr_low ^ pin_io.low_pin_polarity;

  // sync path waits for period
  // Sync mode trades latency for clean edges at period start
  wire ovr_load = ~pin_io.override_sync | period_start_in;
  wire pwmoc_ovr_t ovr_reg = '{pin_io.high_override_en,
    pin_io.low_override_en, pin_io.override_data};

  wire trig_hit = local_time_base_in & time_base_tick_in &
    (time_base_in == trig_cmp);

  // Status is read only; a bit 0 write clears the latch
  wire [15:0] status_word = {10'h000, module_enable_in, unlocked,
    limit_active, fault_active, fault_cycle, fault_latched};

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (sel_pin_io) begin
      rd_mux = pin_io;
    end else if (sel_trig) begin
      rd_mux = trig_cmp;
    end else if (sel_fcl) begin
      rd_mux = fcl;
    end else if (sel_stat) begin
      rd_mux = status_word;
    end
  end

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (avs_read_in & ~ack) begin
        avs_readdata_out <= {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_io <= `PWMOC_RST_PIN_IO;
      fcl <= `PWMOC_RST_FCL;
      trig_cmp <= `PWMOC_RST_TRIG;
    end else begin
      if (wr_pin_io) begin
        pin_io <= next_pin_io;
      end
      if (wr_fcl) begin
        fcl <= next_fcl;
      end
      if (wr_trig) begin
        trig_cmp <= next_trig;
      end
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  // Unlock grants exactly one guarded write, then relocks
  // Any other write between the keys restarts the sequence
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      key_seen <= 1'b0;
      unlocked <= 1'b0;
    end else if (wr_unlock) begin
      key_seen <= wdata == `PWMOC_KEY_FIRST;
      unlocked <= key_seen & (wdata == `PWMOC_KEY_SECOND);
    end else if (wr_go) begin
      key_seen <= 1'b0;
      if (sel_pin_io | sel_fcl) begin
        unlocked <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault state and push-pull phase
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_latched <= 1'b0;
      fault_cycle <= 1'b0;
      push_phase <= 1'b0;
    end else begin
      if (fault_hit & flt_latched_md) begin
        fault_latched <= 1'b1;
      end else if (wr_stat_clr) begin
        fault_latched <= 1'b0;
      end
      if (fault_hit & flt_cycle_md) begin
        fault_cycle <= 1'b1;
      end else if (period_start_in) begin
        fault_cycle <= 1'b0;
      end
      if (period_start_in) begin
        push_phase <= ~push_phase;
      end
    end
  end

  // ----------------------------------------------------------------
  // Override capture and pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ovr_live <= '0;
    end else if (ovr_load) begin
      ovr_live <= ovr_reg;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      high_output_pin_out <= 1'b0;
      low_output_pin_out <= 1'b0;
      high_output_pin_oe_out <= 1'b0;
      low_output_pin_oe_out <= 1'b0;
      adc_trigger_out <= 1'b0;
    end else begin
      // Registered so a mode change never glitches a gate
      high_output_pin_out <= next_high_pin;
      low_output_pin_out <= next_low_pin;
      high_output_pin_oe_out <= pin_io.high_pin_own;
      low_output_pin_oe_out <= pin_io.low_pin_own;
      adc_trigger_out <= trig_hit;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/pwmoc_checker_sva.sv
// Checker of bus timing, read data and trigger of the PWM output block
`timescale 1ns/10ps
`default_nettype none
module pwmoc_checker (
  // Clock, reset and bus
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Time base and trigger
  input wire logic time_base_tick_in,
  input wire logic [15:0] time_base_in,
  input wire logic local_time_base_in,
  input wire logic adc_trigger_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic [15:0] trig_copy;
  wire logic req = avs_read_in | avs_write_in;
  wire logic rd_done = avs_read_in & ~avs_waitrequest_out;
  wire logic wr_done = avs_write_in & ~avs_waitrequest_out;
  wire logic mapped = (avs_address_in[1:0] == 2'h0) &
    (avs_address_in <= 5'h10);
  wire logic hit = local_time_base_in & time_base_tick_in &
    (time_base_in == trig_copy);
  // Compare value has no lock, so the copy tracks every write
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_copy <= 16'h0000;
    end else if (wr_done & (avs_address_in == 5'h04)) begin
      if (avs_byteenable_in[0]) trig_copy[7:0] <= avs_writedata_in[7:0];
      if (avs_byteenable_in[1]) trig_copy[15:8] <= avs_writedata_in[15:8];
    end
  end
  chk_wait_first: assert property (
    req && !$past(req) |-> avs_waitrequest_out)
    else $error("no wait state on a new request");
  chk_wait_once: assert property (
    req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait state longer than one cycle");
  chk_wait_idle: assert property (
    !req |-> !avs_waitrequest_out)
    else $error("waitrequest without a request");
  chk_read_upper: assert property (
    avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_read_hold: assert property (
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved without a read");
  chk_read_unmap: assert property (
    rd_done && !mapped |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_trig_read: assert property (
    rd_done && avs_address_in == 5'h04 |->
    avs_readdata_out[15:0] == trig_copy)
    else $error("compare value read back wrong");
  chk_trig_fire: assert property (
    hit |=> adc_trigger_out)
    else $error("missing trigger on match");
  chk_trig_quiet: assert property (
    !hit |=> !adc_trigger_out)
    else $error("trigger without a match");
  cover property (hit);
  cover property (wr_done);
  cover property (rd_done && !mapped);
endmodule
bind pwmoc_top pwmoc_checker pwmoc_checker_inst (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .time_base_tick_in(time_base_tick_in), .time_base_in(time_base_in),
  .local_time_base_in(local_time_base_in),
  .adc_trigger_out(adc_trigger_out));
`default_nettype wire

// >>> testbench/pwmoc_power_stage.sv
// Power stage model driven by the PWM pins, with an over-current sense
`timescale 1ns/10ps
`default_nettype none
module pwmoc_power_stage (
  // Pins from the block
  input wire logic high_pin_in,
  input wire logic low_pin_in,
  input wire logic high_oe_in,
  input wire logic low_oe_in,
  // Bench control
  input wire logic overload_in,
  // Stage state
  output logic high_gate_out,
  output logic low_gate_out,
  output logic over_current_out,
  output logic shoot_through_out
);
  // gate follows pin only when owned
  // Gate pull-downs, so a released pin reads low, never its last value
  assign high_gate_out = high_oe_in ? high_pin_in : 1'b0;
  assign low_gate_out = low_oe_in ? low_pin_in : 1'b0;
  assign shoot_through_out = high_gate_out & low_gate_out;
  // Sense kept apart from the gates to avoid a feedback loop
  assign over_current_out = overload_in;
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench of the PWM output and limit control block
`timescale 1ns/10ps
`default_nettype none
`include "pwmoc_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  import pwmoc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0, wr = 1'b0, gen = 1'b0, pst = 1'b0, tick = 1'b0;
  logic loc = 1'b0, men = 1'b0, lock = 1'b0, f32 = 1'b0, ovl = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0, cmp_hi = 4'h0;
  logic [15:0] tbase = 16'h0000, q, v;
  logic [7:0] flt = 8'h00;
  logic [1:0] p0;
  wire logic [31:0] rdata;
  wire logic wreq, hp, lp, hoe, loe, trg, oc;
  wire logic hg, lg, sht;
  wire logic [4:0] cmp = {cmp_hi, oc};
  int err_total = 0, checks_done = 0;
  pwmoc_pin_io_t io;
  pwmoc_fcl_t fc;
  pwmoc_top pwmoc_top_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .pwm_gen_in(gen), .period_start_in(pst), .time_base_tick_in(tick),
    .time_base_in(tbase), .local_time_base_in(loc), .module_enable_in(men),
    .write_lock_config_in(lock), .fault_inputs_in(flt),
    .comparator_in(cmp), .fault32_in(f32), .high_output_pin_out(hp),
    .low_output_pin_out(lp), .high_output_pin_oe_out(hoe),
    .low_output_pin_oe_out(loe), .adc_trigger_out(trg));
  pwmoc_power_stage pwmoc_power_stage_inst (.high_pin_in(hp),
    .low_pin_in(lp), .high_oe_in(hoe), .low_oe_in(loe), .overload_in(ovl),
    .high_gate_out(hg), .low_gate_out(lg), .over_current_out(oc),
    .shoot_through_out(sht));
  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic final_report();
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk_in);
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {16'h0000, d};
    be <= 4'h3;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      final_report();
    end else begin
      r = rdata[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task automatic wrt(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, q);
    `CHK("read data", e, q)
  endtask
  task automatic pulse();
    @(posedge ref_clk_in);
    pst <= 1'b1;
    @(posedge ref_clk_in);
    pst <= 1'b0;
    wt(3);
  endtask
  function automatic logic src_lvl(input logic [4:0] s);
    if (s <= 5'h07) return flt[s[2:0]];
    if (s <= 5'h0c) return cmp[3'(s - 5'h08)];
    return (s == 5'h1f) ? f32 : 1'b0;
  endfunction
  // Pair mode, swap, limit, override, then polarity
  function automatic logic [1:0] exp_pins(input pwmoc_pin_io_t c,
    input pwmoc_fcl_t f);
    logic [1:0] p;
    case (c.pin_pair_mode)
      PWMOC_PAIR_COMPL: p = {gen, ~gen};
      PWMOC_PAIR_REDUN: p = {gen, gen};
      default: p = 2'b00;
    endcase
    if (c.swap) p = {p[0], p[1]};
    if (f.limit_mode_en & (src_lvl(f.limit_source_sel) ^ f.limit_polarity))
      p = c.limit_pin_data;
    if (c.high_override_en) p[1] = c.override_data[1];
    if (c.low_override_en) p[0] = c.override_data[0];
    return p ^ {c.high_pin_polarity, c.low_pin_polarity};
  endfunction
  initial begin
    void'($urandom(97767));
    wt(3);
    reset_n_in <= 1'b1;
    rchk(`PWMOC_OFS_PIN_IO, 16'hc000);
    rchk(`PWMOC_OFS_FCL, 16'h00f8);
    rchk(`PWMOC_OFS_TRIG, 16'h0000);
    `CHK("own bits", 2'b11, {hoe, loe})
    // Changes made with the module disabled only
    for (int i = 0; i < 24; i++) begin
      io = 16'($urandom);
      io.override_sync = 1'b0;
      if (io.pin_pair_mode == PWMOC_PAIR_PUSHP) begin
        io.pin_pair_mode = PWMOC_PAIR_RSVD;
      end
      fc = 16'($urandom);
      fc.fault_mode = PWMOC_FLT_OFF;
      fc.limit_source_sel = (i % 3 == 0) ? 5'h08 : 5'($urandom_range(12));
      if (i % 5 == 4) fc.limit_source_sel = 5'h1f;
      wrt(`PWMOC_OFS_FCL, fc);
      wrt(`PWMOC_OFS_PIN_IO, io);
      gen <= 1'($urandom);
      flt <= 8'($urandom);
      cmp_hi <= 4'($urandom);
      f32 <= 1'($urandom);
      ovl <= 1'($urandom);
      wt(4);
      `CHK("pins", exp_pins(io, fc), {hp, lp})
      `CHK("own", {io.high_pin_own, io.low_pin_own}, {hoe, loe})
      p0 = exp_pins(io, fc) & {io.high_pin_own, io.low_pin_own};
      `CHK("gates", p0, {hg, lg})
    end
    wrt(`PWMOC_OFS_FCL, 16'h00fb);
    wrt(`PWMOC_OFS_PIN_IO, 16'hc800);
    gen <= 1'b1;
    wt(4);
    p0 = {hp, lp};
    `CHK("push pull one", 1'b1, ^p0)
    `CHK("shoot through", 1'b0, sht)
    pulse();
    `CHK("push pull alt", {p0[0], p0[1]}, {hp, lp})
    wrt(`PWMOC_OFS_PIN_IO, 16'hc001);
    gen <= 1'b0;
    pulse();
    wrt(`PWMOC_OFS_PIN_IO, 16'hc381);
    wt(4);
    `CHK("sync hold", 2'b01, {hp, lp})
    pulse();
    `CHK("sync apply", 2'b10, {hp, lp})
    wrt(`PWMOC_OFS_PIN_IO, 16'hc340);
    wt(3);
    `CHK("no sync", 2'b01, {hp, lp})
    f32 <= 1'b0;
    lock <= 1'b1;
    wrt(`PWMOC_OFS_PIN_IO, 16'hc000);
    rchk(`PWMOC_OFS_PIN_IO, 16'hc340);
    wrt(`PWMOC_OFS_FCL, 16'h00f8);
    rchk(`PWMOC_OFS_FCL, 16'h00fb);
    for (int k = 0; k < 2; k++) begin
      wrt(`PWMOC_OFS_UNLOCK, `PWMOC_KEY_FIRST);
      wrt(`PWMOC_OFS_UNLOCK, `PWMOC_KEY_SECOND);
      wrt(k ? `PWMOC_OFS_FCL : `PWMOC_OFS_PIN_IO, 16'h0000);
      rchk(k ? `PWMOC_OFS_FCL : `PWMOC_OFS_PIN_IO, 16'h0000);
    end
    wrt(`PWMOC_OFS_PIN_IO, 16'hc004);
    rchk(`PWMOC_OFS_PIN_IO, 16'h0000);
    rchk(5'h14, 16'h0000);
    lock <= 1'b0;
    flt <= 8'h00;
    wrt(`PWMOC_OFS_STATUS, 16'h0001);
    wrt(`PWMOC_OFS_PIN_IO, 16'hc010);
    gen <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wrt(`PWMOC_OFS_FCL, 16'(m));
      flt <= 8'h01;
      wt(3);
      `CHK("fault forced", 2'b01, {hp, lp})
      flt <= 8'h00;
      wt(3);
      `CHK("fault held", 2'b01, {hp, lp})
      rchk(`PWMOC_OFS_STATUS, m ? 16'h0006 : 16'h0005);
      if (m == 0) wrt(`PWMOC_OFS_STATUS, 16'h0001);
      else pulse();
      wt(3);
      `CHK("fault released", 2'b10, {hp, lp})
    end
    v = 16'($urandom);
    wrt(`PWMOC_OFS_TRIG, v);
    men <= 1'b1;
    rchk(`PWMOC_OFS_STATUS, 16'h0020);
    for (int t = 0; t < 3; t++) begin
      @(posedge ref_clk_in);
      loc <= (t != 1);
      tbase <= (t == 2) ? v + 16'h0001 : v;
      tick <= 1'b1;
      @(posedge ref_clk_in);
      tick <= 1'b0;
      @(posedge ref_clk_in);
      `CHK("trigger", (t == 0), trg)
    end
    final_report();
  end
endmodule
`default_nettype wire
